// ---- include/ebp_pkg.sv ----
package ebp_pkg;
    localparam int ADDR_W    = 26;
    localparam int DATA_W    = 32;
    localparam int HALF_W    = 16;
    localparam int AREA_W    = 3;
    localparam int MROM_N    = 8;
    localparam int LANE_N    = 4;
    // area encodings of the physical map
    localparam logic [2:0] AREA0 = 3'h0;
    localparam logic [2:0] AREA2 = 3'h2;
    localparam logic [2:0] AREA3 = 3'h3;
    localparam logic [2:0] AREA4 = 3'h4;
    localparam logic [2:0] AREA5 = 3'h5;
    localparam logic [2:0] AREA6 = 3'h6;
    // region split bit for the two row/column strobe pairs (32 Mbyte)
    localparam int UPPER_BIT = 25;
    // bus width codes
    localparam logic [1:0] WIDTH8  = 2'h0;
    localparam logic [1:0] WIDTH16 = 2'h1;
    localparam logic [1:0] WIDTH32 = 2'h2;
    // memory types
    typedef enum logic [1:0] {
        EBP_MEM_PLAIN = 2'b00,
        EBP_MEM_SDRAM = 2'b01,
        EBP_MEM_CARD  = 2'b10
    } ebp_mem_t;
    typedef enum logic [2:0] {
        EBP_ST_IDLE  = 3'b000,
        EBP_ST_START = 3'b001,
        EBP_ST_DATA  = 3'b010,
        EBP_ST_END   = 3'b011,
        EBP_ST_REL   = 3'b100
    } ebp_state_t;
    localparam logic [3:0] LANES_NONE = 4'h0;
    localparam logic [7:0] MROM_NONE  = 8'h00;
endpackage : ebp_pkg

// ---- core/ebp_sync.sv ----
`timescale 1ns/1ps
module ebp_sync (
    input  wire logic clock_i,
    input  wire logic reset_n_i,
    input  wire logic async_i,
    input  wire logic reset_val_i,
    output logic      sync_o
);
    logic meta_r;
    // reset level is fixed high; reset_val_i is left unused
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_r <= 1'b1;
            sync_o <= 1'b1;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
    logic unused_w;
    assign unused_w = reset_val_i;
endmodule : ebp_sync

// ---- core/ebp_bus_pins.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - start strobe each cycle and each burst beat
// - upper data lanes only at 32-bit width
// - one chip select per accessed area
// - areas 5/6 selects double as card enables
// - lane strobes write bytes for plain memory
// - lane strobes are data masks for DRAM
// - card: lane1 write, lane2 ioread, lane3 iowrite
// - direction line shows write, also for cards
// - read strobe during read cycles
// - lower row/column strobes for lower region
// - upper row/column strobes for upper region
// - drive DRAM clock enable output
// - wait input stretches current cycle
// - card 16-bit flag only in little-endian
// - release bus on request, then acknowledge
// - eight mask ROM selects, areas 0/2
// - second card-enable pair, one per area 5/6, follows the odd byte
module ebp_bus_pins #(
    parameter int BEATS_MAX = 4
) (
    input  wire logic                        clock_i,
    input  wire logic                        reset_n_i,
    // internal request side
    input  wire logic                        req_valid_i,
    output logic                             req_ready_o,
    input  wire logic                        req_write_i,
    input  wire logic [ebp_pkg::AREA_W-1:0]  req_area_i,
    input  wire logic [ebp_pkg::ADDR_W-1:0]  req_addr_i,
    input  wire logic [ebp_pkg::DATA_W-1:0]  req_wdata_i,
    input  wire logic [ebp_pkg::LANE_N-1:0]  req_lanes_i,
    input  wire logic [1:0]                  req_width_i,
    input  wire ebp_pkg::ebp_mem_t           req_mem_i,
    input  wire logic [2:0]                  req_beats_i,
    input  wire logic [ebp_pkg::MROM_N-1:0]  req_mrom_i,
    input  wire logic                        little_endian_i,
    input  wire logic                        sdram_cke_i,
    output logic                             done_o,
    output logic [ebp_pkg::DATA_W-1:0]       rdata_o,
    output logic                             io16_o,
    // pins
    output logic [ebp_pkg::ADDR_W-1:0]       addr_o,
    input  wire logic [ebp_pkg::DATA_W-1:0]  data_i,
    output logic [ebp_pkg::DATA_W-1:0]       data_o,
    output logic [1:0]                       data_oe_o,
    output logic                             cycle_start_strobe_n_o,
    output logic [3:0]                       area_selects_low_n_o,
    output logic                             area5_select_card_enable_n_o,
    output logic                             area6_select_card_enable_n_o,
    output logic [1:0]                       card_enable_second_pair_n_o,
    output logic                             rd_wr_o,
    output logic                             read_strobe_n_o,
    output logic                             row_strobe_lower_n_o,
    output logic                             row_strobe_upper_n_o,
    output logic                             column_strobe_lower_n_o,
    output logic                             column_strobe_upper_n_o,
    output logic                             lane0_strobe_n_o,
    output logic                             lane1_strobe_n_o,
    output logic                             lane2_strobe_n_o,
    output logic                             lane3_strobe_n_o,
    output logic                             clock_enable_o,
    input  wire logic                        wait_n_i,
    input  wire logic                        io16_n_i,
    input  wire logic                        bus_release_request_n_i,
    output logic                             bus_release_ack_n_o,
    output logic [ebp_pkg::MROM_N-1:0]       mask_rom_selects_n_o
);
    import ebp_pkg::*;

    // refuse burst limits the 3-bit beat counter cannot hold
    if (BEATS_MAX < 1 || BEATS_MAX > 7) begin : g_bad_beats
        $error("BEATS_MAX must be 1 to 7");
    end
    if (UPPER_BIT >= ADDR_W) begin : g_bad_split
        $error("UPPER_BIT must lie inside the address");
    end

    // wait, release and io16 pin inputs pass two stages: two cycles of lag
    logic wait_n_s;
    logic rel_req_n_s;
    logic io16_n_s;

    ebp_sync u_sync_wait (
        .clock_i     (clock_i),
        .reset_n_i   (reset_n_i),
        .async_i     (wait_n_i),
        .reset_val_i (1'b1),
        .sync_o      (wait_n_s)
    );
    ebp_sync u_sync_rel_req (
        .clock_i     (clock_i),
        .reset_n_i   (reset_n_i),
        .async_i     (bus_release_request_n_i),
        .reset_val_i (1'b1),
        .sync_o      (rel_req_n_s)
    );
    ebp_sync u_sync_io16 (
        .clock_i     (clock_i),
        .reset_n_i   (reset_n_i),
        .async_i     (io16_n_i),
        .reset_val_i (1'b1),
        .sync_o      (io16_n_s)
    );

    // burst length: zero means one beat, longer asks are clamped
    logic [2:0] beats_req;
    always_comb begin
        if (req_beats_i == 3'h0) begin
            beats_req = 3'h1;
        end else if (req_beats_i > 3'(BEATS_MAX)) begin
            beats_req = 3'(BEATS_MAX);
        end else begin
            beats_req = req_beats_i;
        end
    end

    typedef struct packed {
        ebp_state_t          state;
        logic                write;
        logic [AREA_W-1:0]   area;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
        logic [LANE_N-1:0]   lanes;
        logic [1:0]          width;
        ebp_mem_t            mem;
        logic [2:0]          beats;
        logic [MROM_N-1:0]   mrom;
        logic                done;
        logic [DATA_W-1:0]   rdata;
        logic                io16;
        logic                cke;
    } ebp_regs_t;

    ebp_regs_t s_r;
    ebp_regs_t s_nxt;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        s_nxt.cke  = sdram_cke_i;
        case (s_r.state)
            EBP_ST_IDLE: begin
                if (!rel_req_n_s) begin
                    s_nxt.state = EBP_ST_REL;
                end else if (req_valid_i) begin
                    s_nxt.state = EBP_ST_START;
                    s_nxt.write = req_write_i;
                    s_nxt.area  = req_area_i;
                    s_nxt.addr  = req_addr_i;
                    s_nxt.wdata = req_wdata_i;
                    s_nxt.lanes = req_lanes_i;
                    s_nxt.width = req_width_i;
                    s_nxt.mem   = req_mem_i;
                    s_nxt.beats = beats_req;
                    s_nxt.mrom  = req_mrom_i;
                end
            end
            EBP_ST_START: begin
                // row strobe and selects shown here
                s_nxt.state = EBP_ST_DATA;
            end
            EBP_ST_DATA: begin
                // wait stretch
                // read data taken as the wait lifts
                if (wait_n_s) begin
                    s_nxt.rdata = data_i;
                    s_nxt.done  = 1'b1;
                    s_nxt.io16  = little_endian_i && !io16_n_s
                                  && s_r.mem == EBP_MEM_CARD;
                    if (s_r.beats > 3'h1) begin
                        s_nxt.beats = s_r.beats - 3'h1;
                        s_nxt.addr  = s_r.addr + ADDR_W'(4);
                        s_nxt.state = EBP_ST_START;
                    end else begin
                        s_nxt.state = EBP_ST_END;
                    end
                end
            end
            EBP_ST_END: begin
                s_nxt.state = EBP_ST_IDLE;
            end
            EBP_ST_REL: begin
                // hold the bus off until the request drops
                if (rel_req_n_s) begin
                    s_nxt.state = EBP_ST_IDLE;
                end
            end
            default: begin
                s_nxt.state = EBP_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_r <= '{state: EBP_ST_IDLE, mem: EBP_MEM_PLAIN, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    logic active;
    logic strobe_ph;
    logic card;
    logic sdram;
    // strobes, selects and drive enables gated by the active phase
    assign active    = s_r.state == EBP_ST_START
                       || s_r.state == EBP_ST_DATA;
    assign strobe_ph = s_r.state == EBP_ST_DATA;
    assign card      = s_r.mem == EBP_MEM_CARD;
    assign sdram     = s_r.mem == EBP_MEM_SDRAM;

    // combinational, so a request lands on the next edge
    assign req_ready_o = s_r.state == EBP_ST_IDLE && rel_req_n_s;
    assign done_o      = s_r.done;
    assign rdata_o     = s_r.rdata;
    assign io16_o      = s_r.io16;
    assign addr_o      = s_r.addr;
    assign data_o      = s_r.wdata;
    assign clock_enable_o = s_r.cke;
    assign bus_release_ack_n_o = s_r.state != EBP_ST_REL;

    always_comb begin
        data_oe_o = 2'h0;
        if (active && s_r.write) begin
            data_oe_o[0] = 1'b1;
            // narrower widths leave the upper half undriven
            data_oe_o[1] = s_r.width == WIDTH32;
        end
    end

    assign cycle_start_strobe_n_o = s_r.state != EBP_ST_START;

    always_comb begin
        area_selects_low_n_o = 4'hf;
        if (active) begin
            if (s_r.area == AREA0) begin
                area_selects_low_n_o[0] = 1'b0;
            end else if (s_r.area == AREA2) begin
                area_selects_low_n_o[1] = 1'b0;
            end else if (s_r.area == AREA3) begin
                area_selects_low_n_o[2] = 1'b0;
            end else if (s_r.area == AREA4) begin
                area_selects_low_n_o[3] = 1'b0;
            end
        end
    end
    always_comb begin
        area5_select_card_enable_n_o = 1'b1;
        area6_select_card_enable_n_o = 1'b1;
        card_enable_second_pair_n_o  = 2'h3;
        if (active && s_r.area == AREA5) begin
            area5_select_card_enable_n_o = 1'b0;
            // second pair follows the odd byte
            card_enable_second_pair_n_o[0] = !(card && s_r.lanes[1]);
        end else if (active && s_r.area == AREA6) begin
            area6_select_card_enable_n_o = 1'b0;
            card_enable_second_pair_n_o[1] = !(card && s_r.lanes[1]);
        end
    end

    always_comb begin
        rd_wr_o         = 1'b1;
        read_strobe_n_o = 1'b1;
        if (active && s_r.write) begin
            rd_wr_o = 1'b0;
        end
        if (strobe_ph && !s_r.write) begin
            // read strobe in the data phase only
            read_strobe_n_o = 1'b0;
        end
    end

    // one row/column pair per 32 Mbyte region
    logic upper_region;
    logic row_ph;
    assign upper_region = s_r.addr[UPPER_BIT];
    assign row_ph       = s_r.state == EBP_ST_START;
    always_comb begin
        row_strobe_lower_n_o    = 1'b1;
        row_strobe_upper_n_o    = 1'b1;
        column_strobe_lower_n_o = 1'b1;
        column_strobe_upper_n_o = 1'b1;
        if (sdram) begin
            if (!upper_region) begin
                // lower 32 Mbyte region (address bit 25 clear)
                row_strobe_lower_n_o    = !row_ph;
                column_strobe_lower_n_o = !strobe_ph;
            end else begin
                row_strobe_upper_n_o    = !row_ph;
                column_strobe_upper_n_o = !strobe_ph;
            end
        end
    end

    always_comb begin
        lane0_strobe_n_o = 1'b1;
        lane1_strobe_n_o = 1'b1;
        lane2_strobe_n_o = 1'b1;
        lane3_strobe_n_o = 1'b1;
        if (active && sdram) begin
            // masks high on lanes not selected
            lane0_strobe_n_o = !s_r.lanes[0];
            lane1_strobe_n_o = !s_r.lanes[1];
            lane2_strobe_n_o = !s_r.lanes[2];
            lane3_strobe_n_o = !s_r.lanes[3];
        end else if (strobe_ph && card) begin
            // card cycles are run as I/O cycles
            lane1_strobe_n_o = !s_r.write;
            lane2_strobe_n_o = s_r.write;
            lane3_strobe_n_o = !s_r.write;
        end else if (strobe_ph && s_r.write) begin
            lane0_strobe_n_o = !s_r.lanes[0];
            lane1_strobe_n_o = !s_r.lanes[1];
            lane2_strobe_n_o = !s_r.lanes[2];
            lane3_strobe_n_o = !s_r.lanes[3];
        end
    end

    // mask ROM picks only in areas 0 and 2
    logic mrom_area;
    assign mrom_area = s_r.area == AREA0 || s_r.area == AREA2;
    always_comb begin
        mask_rom_selects_n_o = ~MROM_NONE;
        if (active && mrom_area) begin
            mask_rom_selects_n_o = ~s_r.mrom;
        end
    end
endmodule : ebp_bus_pins

// ---- verif/ebp_bus_pins_assertions.sv ----
`timescale 1ns/1ps
module ebp_bus_pins_chk
    import ebp_pkg::*;
(
    input wire logic               clock_i,
    input wire logic               reset_n_i,
    input wire logic               req_valid_i,
    input wire logic               req_ready_o,
    input wire logic               req_write_i,
    input wire logic [AREA_W-1:0]  req_area_i,
    input wire logic [1:0]         req_width_i,
    input wire logic               sdram_cke_i,
    input wire logic               clock_enable_o,
    input wire logic               cycle_start_strobe_n_o,
    input wire logic               area5_select_card_enable_n_o,
    input wire logic               rd_wr_o,
    input wire logic               read_strobe_n_o,
    input wire logic               lane1_strobe_n_o,
    input wire logic [1:0]         data_oe_o,
    input wire logic               bus_release_request_n_i,
    input wire logic               bus_release_ack_n_o
);
    logic take;
    assign take = req_valid_i && req_ready_o;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    property p_start; take |=> !cycle_start_strobe_n_o; endproperty
    a_start: assert property (p_start) else $error("no start strobe");
    property p_rd; !read_strobe_n_o |-> rd_wr_o; endproperty
    a_rd: assert property (p_rd) else $error("read strobe in write");
    property p_idle; req_ready_o |-> cycle_start_strobe_n_o &&
        read_strobe_n_o && lane1_strobe_n_o && data_oe_o == 2'h0; endproperty
    a_idle: assert property (p_idle) else $error("idle pin active");
    property p_cke; $past(reset_n_i) |->
        clock_enable_o == $past(sdram_cke_i); endproperty
    a_cke: assert property (p_cke) else $error("cke not copied");
    property p_wide; take && req_width_i != WIDTH32 |=>
        (data_oe_o[1] == 1'b0) [*3]; endproperty
    a_wide: assert property (p_wide) else $error("upper half driven");
    property p_ack; $fell(bus_release_ack_n_o) |->
        !$past(bus_release_request_n_i, 2); endproperty
    a_ack: assert property (p_ack) else $error("ack without request");
    property p_ackq; !bus_release_ack_n_o |->
        !req_ready_o && cycle_start_strobe_n_o; endproperty
    a_ackq: assert property (p_ackq) else $error("cycle while released");
    property p_sel; take && req_area_i == AREA5 |=>
        !area5_select_card_enable_n_o; endproperty
    a_sel: assert property (p_sel) else $error("area5 select missing");
    property p_dir; take && req_write_i |=> !rd_wr_o; endproperty
    a_dir: assert property (p_dir) else $error("direction not write");
endmodule : ebp_bus_pins_chk

bind ebp_bus_pins ebp_bus_pins_chk chk (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o),
    .req_write_i(req_write_i),
    .req_area_i(req_area_i),
    .req_width_i(req_width_i),
    .sdram_cke_i(sdram_cke_i),
    .clock_enable_o(clock_enable_o),
    .cycle_start_strobe_n_o(cycle_start_strobe_n_o),
    .area5_select_card_enable_n_o(area5_select_card_enable_n_o),
    .rd_wr_o(rd_wr_o),
    .read_strobe_n_o(read_strobe_n_o),
    .lane1_strobe_n_o(lane1_strobe_n_o),
    .data_oe_o(data_oe_o),
    .bus_release_request_n_i(bus_release_request_n_i),
    .bus_release_ack_n_o(bus_release_ack_n_o)
);

// ---- verif/ebp_mem_model.sv ----
`timescale 1ns/1ps
module ebp_mem_model
    import ebp_pkg::*;
(
    input  wire logic              clock_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic [3:0]        lane_n_i,
    input  wire logic              rd_wr_i,
    input  wire logic              read_n_i,
    input  wire logic              hold_i,
    output logic [DATA_W-1:0]      rdata_o,
    output logic                   wait_n_o
);
    logic [DATA_W-1:0] mem_r [16];
    logic [DATA_W-1:0] last_r;
    initial begin
        foreach (mem_r[i]) mem_r[i] = '0;
        last_r = '0;
    end
    assign wait_n_o = !hold_i;
    always @(posedge clock_i) begin
        for (int b = 0; b < 4; b++) begin
            if (!rd_wr_i && !lane_n_i[b]) begin
                mem_r[addr_i[5:2]][8*b+:8] <= wdata_i[8*b+:8];
            end
        end
        if (!read_n_i) begin
            last_r <= mem_r[addr_i[5:2]];
        end
    end
    // released bus shows no stale value
    assign rdata_o = read_n_i ? ~last_r : mem_r[addr_i[5:2]];
endmodule : ebp_mem_model

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb;
    import ebp_pkg::*;
    logic              clock_i, reset_n_i, req_valid_i, req_ready_o, done_o;
    logic              req_write_i, little_endian_i, sdram_cke_i, io16_o;
    logic [AREA_W-1:0] req_area_i;
    logic [ADDR_W-1:0] req_addr_i, addr_o;
    logic [DATA_W-1:0] req_wdata_i, rdata_o, data_i, data_o, rd;
    logic [3:0]        req_lanes_i, area_selects_low_n_o, lanes_n, s_lane, s_ras;
    logic [1:0]        req_width_i, data_oe_o, card_enable_second_pair_n_o;
    ebp_mem_t          req_mem_i;
    logic [2:0]        req_beats_i;
    logic [MROM_N-1:0] req_mrom_i, mask_rom_selects_n_o, s_mrom;
    logic              io16_n_i, wait_n_i, rd_wr_o, read_strobe_n_o, hold;
    logic              cycle_start_strobe_n_o, bus_release_request_n_i, io;
    logic              bus_release_ack_n_o, clock_enable_o, s_oe1;
    logic              area5_select_card_enable_n_o;
    logic              area6_select_card_enable_n_o;
    logic              row_strobe_lower_n_o, row_strobe_upper_n_o;
    logic              column_strobe_lower_n_o, column_strobe_upper_n_o;
    logic              lane0_strobe_n_o, lane1_strobe_n_o;
    logic              lane2_strobe_n_o, lane3_strobe_n_o;
    logic [1:0]        s_ce2;
    logic [5:0]        s_cs;
    int                errors, n_compared, n_start, lat, cyc;
    assign lanes_n = {lane3_strobe_n_o, lane2_strobe_n_o,
                      lane1_strobe_n_o, lane0_strobe_n_o};
    ebp_bus_pins dut (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o),
        .req_write_i(req_write_i),
        .req_area_i(req_area_i),
        .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i),
        .req_lanes_i(req_lanes_i),
        .req_width_i(req_width_i),
        .req_mem_i(req_mem_i),
        .req_beats_i(req_beats_i),
        .req_mrom_i(req_mrom_i),
        .little_endian_i(little_endian_i),
        .sdram_cke_i(sdram_cke_i),
        .done_o(done_o),
        .rdata_o(rdata_o),
        .io16_o(io16_o),
        .addr_o(addr_o),
        .data_i(data_i),
        .data_o(data_o),
        .data_oe_o(data_oe_o),
        .cycle_start_strobe_n_o(cycle_start_strobe_n_o),
        .area_selects_low_n_o(area_selects_low_n_o),
        .area5_select_card_enable_n_o(area5_select_card_enable_n_o),
        .area6_select_card_enable_n_o(area6_select_card_enable_n_o),
        .card_enable_second_pair_n_o(card_enable_second_pair_n_o),
        .rd_wr_o(rd_wr_o),
        .read_strobe_n_o(read_strobe_n_o),
        .row_strobe_lower_n_o(row_strobe_lower_n_o),
        .row_strobe_upper_n_o(row_strobe_upper_n_o),
        .column_strobe_lower_n_o(column_strobe_lower_n_o),
        .column_strobe_upper_n_o(column_strobe_upper_n_o),
        .lane0_strobe_n_o(lane0_strobe_n_o),
        .lane1_strobe_n_o(lane1_strobe_n_o),
        .lane2_strobe_n_o(lane2_strobe_n_o),
        .lane3_strobe_n_o(lane3_strobe_n_o),
        .clock_enable_o(clock_enable_o),
        .wait_n_i(wait_n_i),
        .io16_n_i(io16_n_i),
        .bus_release_request_n_i(bus_release_request_n_i),
        .bus_release_ack_n_o(bus_release_ack_n_o),
        .mask_rom_selects_n_o(mask_rom_selects_n_o)
    );
    ebp_mem_model far (.clock_i(clock_i), .addr_i(addr_o), .wdata_i(data_o),
        .lane_n_i(lanes_n), .rd_wr_i(rd_wr_o), .read_n_i(read_strobe_n_o),
        .hold_i(hold), .rdata_o(data_i), .wait_n_o(wait_n_i));
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    task automatic complete_run;
        if (errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [DATA_W-1:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, got, exp);
        end
    endtask : check
    // one request, then watch the pins until every beat is done
    task automatic xfer(input logic wr, input logic [2:0] ar,
        input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] wd,
        input logic [3:0] ln, input logic [1:0] wi, input ebp_mem_t mt,
        input logic [2:0] bt);
        int t;
        int nd;
        {t, nd, n_start, lat} = '0;
        {s_lane, s_ras, s_mrom, s_ce2, s_oe1, s_cs} = '0;
        {req_write_i, req_area_i, req_addr_i, req_wdata_i} = {wr, ar, ad, wd};
        {req_lanes_i, req_width_i, req_beats_i} = {ln, wi, bt};
        req_mem_i = mt;
        req_valid_i = 1'b1;
        while (!req_ready_o && t < 50) begin
            @(negedge clock_i);
            t++;
        end
        @(negedge clock_i);
        req_valid_i = 1'b0;
        t = 0;
        while (nd < bt && t < 60) begin
            n_start += !cycle_start_strobe_n_o;
            s_lane |= ~lanes_n;
            s_ras |= ~{row_strobe_upper_n_o, row_strobe_lower_n_o,
                       column_strobe_upper_n_o, column_strobe_lower_n_o};
            s_mrom |= ~mask_rom_selects_n_o;
            s_ce2 |= ~card_enable_second_pair_n_o;
            s_oe1 |= data_oe_o[1];
            s_cs |= ~{area6_select_card_enable_n_o,
                      area5_select_card_enable_n_o, area_selects_low_n_o};
            if (done_o) begin
                nd++;
                rd = rdata_o;
                io = io16_o;
                if (lat == 0) lat = t;
            end
            @(negedge clock_i);
            t++;
        end
        check(nd, bt);
    endtask : xfer
    task automatic t_plain;
        xfer(1, AREA0, 'h10, 'h11223344, 4'hf, WIDTH32, EBP_MEM_PLAIN, 1);
        check({lat[7:0], s_lane, s_oe1}, {8'd2, 4'hf, 1'b1});
        check(s_cs, 6'h01);
        xfer(1, AREA0, 'h10, 'haabbccdd, 4'h2, WIDTH32, EBP_MEM_PLAIN, 1);
        check(s_lane, 4'h2);
        xfer(0, AREA0, 'h10, 0, 4'hf, WIDTH32, EBP_MEM_PLAIN, 1);
        check({rd, s_lane}, {32'h1122cc44, 4'h0});
        xfer(1, AREA4, 'h20, 'h5a5a5a5a, 4'h3, WIDTH16, EBP_MEM_PLAIN, 1);
        check(s_oe1, 1'b0);
        check(s_cs, 6'h08);
        xfer(0, AREA3, 'h10, 0, 4'hf, WIDTH32, EBP_MEM_PLAIN, 4);
        check(n_start, 4);
        check(s_cs, 6'h04);
    endtask : t_plain
    task automatic t_sdram;
        sdram_cke_i = 1'b1;
        @(negedge clock_i);
        check(clock_enable_o, 1'b1);
        xfer(0, AREA2, 'h0000040, 0, 4'h3, WIDTH32, EBP_MEM_SDRAM, 1);
        check({s_ras, s_lane}, {4'b0101, 4'h3});
        check(s_cs, 6'h02);
        xfer(1, AREA3, 'h2000040, 'h1, 4'hc, WIDTH16, EBP_MEM_SDRAM, 1);
        check({s_ras, s_lane}, {4'b1010, 4'hc});
    endtask : t_sdram
    task automatic t_card;
        io16_n_i = 1'b0;
        xfer(1, AREA5, 'h4, 'h0000ee00, 4'h2, WIDTH16, EBP_MEM_CARD, 1);
        check({s_lane, s_ce2}, {4'ha, 2'b01});
        check(s_cs, 6'h10);
        xfer(0, AREA6, 'h4, 0, 4'h2, WIDTH16, EBP_MEM_CARD, 1);
        check(io, 1'b0);
        check(s_cs, 6'h20);
        little_endian_i = 1'b1;
        xfer(0, AREA6, 'h4, 0, 4'h2, WIDTH16, EBP_MEM_CARD, 1);
        check({io, s_ce2}, {1'b1, 2'b10});
        io16_n_i = 1'b1;
    endtask : t_card
    task automatic t_other;
        int t;
        req_mrom_i = 8'h04;
        xfer(0, AREA0, 'h8, 0, 4'hf, WIDTH32, EBP_MEM_PLAIN, 1);
        check(s_mrom, 8'h04);
        req_mrom_i = 8'h00;
        hold = 1'b1;
        fork
            xfer(0, AREA4, 'h8, 0, 4'hf, WIDTH32, EBP_MEM_PLAIN, 1);
            begin
                repeat (10) @(negedge clock_i);
                hold = 1'b0;
            end
        join
        check({lat > 7, lat < 16}, 2'h3);
        bus_release_request_n_i = 1'b0;
        for (t = 0; t < 6 && bus_release_ack_n_o; t++) @(negedge clock_i);
        check({bus_release_ack_n_o, req_ready_o}, 2'h0);
        bus_release_request_n_i = 1'b1;
        for (t = 0; t < 6 && !bus_release_ack_n_o; t++) @(negedge clock_i);
        repeat (2) @(negedge clock_i);
        check({bus_release_ack_n_o, req_ready_o}, 2'h3);
    endtask : t_other
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            complete_run();
        end
    end
    initial begin
        {req_valid_i, req_write_i, req_area_i, req_addr_i} = '0;
        {req_wdata_i, req_lanes_i, req_width_i, req_beats_i} = '0;
        {req_mrom_i, little_endian_i, sdram_cke_i, hold} = '0;
        {io16_n_i, bus_release_request_n_i} = 2'h3;
        {errors, n_compared, cyc} = '0;
        req_mem_i = EBP_MEM_PLAIN;
        reset_n_i = 1'b0;
        repeat (4) @(negedge clock_i);
        check({cycle_start_strobe_n_o, read_strobe_n_o, lanes_n,
            bus_release_ack_n_o, area_selects_low_n_o, data_oe_o,
            clock_enable_o}, 14'h3ff8);
        reset_n_i = 1'b1;
        t_plain();
        t_sdram();
        t_card();
        t_other();
        complete_run();
    end
endmodule : tb
